// File: design/sdac_pkg.sv
// Functional notes
// RULE1 - Power-down bit overrides everything, all sections off
// RULE2 - Sleep keeps bandgap, amplifier, filter on
// RULE3 - All bits low gives normal conversion
// RULE4 - Filter reset bit holds filter in reset
// RULE5 - Host pulses filter reset; conversions follow release
// RULE6 - Finished conversion sets done flag
// RULE7 - Without hold, each result overwrites registers
// RULE8 - With hold, latest result stays frozen
// RULE9 - Reference pair chosen by select bit
// RULE10 - Result is 24-bit two's complement
// RULE11 - Results saturate at full-scale codes
// RULE12 - Three read-only result bytes, consecutive addresses
// RULE13 - Host keeps trim register at fixed pattern
// RULE14 - Host configures, powers up, resets, polls, reads
// RULE15 - Host programs clock divider for nominal clock
// RULE16 - Temperature sensor on only when selected
// RULE17 - Reference buffers follow own enables independently
// RULE18 - Only host clears done flag
// RULE19 - Filter reset aborts and blocks conversion
// RULE20 - Hold bit gates result update only
// RULE21 - Oversample code sets ratio 32768 down to 128
// RULE22 - All three bytes update from one sample
// RULE23 - Mode priority: power-down, sleep, filter reset
package sdac_pkg;
   // Device register offsets
   localparam logic [7:0] ADDR_RES_LOW  = 8'h04;
   localparam logic [7:0] ADDR_RES_MID  = 8'h05;
   localparam logic [7:0] ADDR_RES_HIGH = 8'h06;
   localparam logic [7:0] ADDR_CTRL0    = 8'h07;
   localparam logic [7:0] ADDR_CTRL1    = 8'h08;
   localparam logic [7:0] ADDR_CLKSEL   = 8'h09;
   localparam logic [7:0] ADDR_TRIM     = 8'h0a;
   localparam logic [7:0] ADDR_INSEL    = 8'h0b;
   // Control 0 fields
   localparam int C0_FRST  = 7;
   localparam int C0_SLEEP = 6;
   localparam int C0_PDOWN = 5;
   localparam int C0_OSR   = 1;
   localparam int C0_REFS  = 0;
   // Control 1 fields
   localparam int C1_RATE  = 5;
   localparam int C1_NBUF  = 4;
   localparam int C1_PBUF  = 3;
   localparam int C1_HOLD  = 2;
   localparam int C1_DONE  = 1;
   // Input select fields
   localparam int IS_NEG   = 3;
   localparam int IS_POS   = 0;
   localparam logic [2:0] SEL_TEMP = 3'h7;
   // Reset values and host-written patterns
   localparam logic [7:0] RST_CTRL0  = 8'h20;
   localparam logic [7:0] RST_CTRL1  = 8'h00;
   localparam logic [7:0] RST_CLKSEL = 8'h00;
   localparam logic [7:0] RST_TRIM   = 8'he4;
   localparam logic [7:0] TRIM_REQ   = 8'he7;
   localparam logic [7:0] RST_INSEL  = 8'h00;
   localparam logic [7:0] CLKSEL_NOM = 8'h1f;
   // Oversampling
   localparam logic [3:0] OSR_MAX_CODE = 4'h8;
   localparam int OSR_BASE_LOG = 15;
   // Saturation limits
   localparam logic signed [23:0] RES_MAX = 24'sh7fffff;
   localparam logic signed [23:0] RES_MIN = 24'sh800000;
   // Host command codes
   localparam logic [1:0] CMD_WRITE = 2'h1;
   localparam logic [1:0] CMD_READ  = 2'h2;
   localparam logic [1:0] CMD_START = 2'h3;
   // Host command register offsets (Avalon word addresses)
   localparam logic [3:0] HA_CMD    = 4'h0;
   localparam logic [3:0] HA_STATUS = 4'h4;
   localparam logic [3:0] HA_RESULT = 4'h8;

   typedef enum logic [2:0] {
      SDAC_PDOWN = 3'b001,
      SDAC_SLEEP = 3'b010,
      SDAC_RUN   = 3'b100
   } sdac_mode_e;

   function automatic logic signed [23:0] sdac_sat(input logic signed [25:0] v);
      if (v > 26'(RES_MAX)) return RES_MAX;
      else if (v < 26'(RES_MIN)) return RES_MIN;
      else return v[23:0];
   endfunction
endpackage

// File: design/sdac_if.sv
`timescale 1ns/1ps
interface sdac_if;
   logic       wr;
   logic       rd;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic [7:0] rdata;
   modport dev  (input wr, rd, addr, wdata, output rdata);
   modport host (output wr, rd, addr, wdata, input rdata);
endinterface

// File: design/sdac_dev.sv
// The implementer's own choice: the Avalon-MM slave port.
`timescale 1ns/1ps
module sdac_dev (
   // Clock and reset
   input  wire logic               clk_i,
   input  wire logic               srst_i,
   // Register port
   sdac_if.dev                     bus,
   // Modulator sample
   input  wire logic signed [25:0] sample_i,
   input  wire logic               sample_valid_i,
   // Analog enables and settings
   output logic                    bandgap_en_o,
   output logic                    amp_en_o,
   output logic                    mod_en_o,
   output logic                    temp_en_o,
   output logic                    nbuf_en_o,
   output logic                    pbuf_en_o,
   output logic                    filter_en_o,
   output logic                    filter_rst_o,
   output logic                    ref_ext_o,
   output logic [3:0]              osr_code_o,
   output logic [2:0]              rate_div_o,
   output logic [4:0]              clk_div_o
);
   logic [7:0]         ctrl0;
   logic [7:0]         ctrl1;
   logic [7:0]         clksel;
   logic [7:0]         trim;
   logic [7:0]         insel;
   logic [23:0]        result;
   logic [15:0]        dec_cnt;
   logic [15:0]        dec_len;
   logic signed [25:0] acc;
   logic               armed;
   logic               done;
   sdac_pkg::sdac_mode_e mode;

   always_comb begin
      if (ctrl0[sdac_pkg::C0_PDOWN]) mode = sdac_pkg::SDAC_PDOWN; // RULE23
      else if (ctrl0[sdac_pkg::C0_SLEEP]) mode = sdac_pkg::SDAC_SLEEP;
      else mode = sdac_pkg::SDAC_RUN;
   end

   // Unused reserved codes fall back to the shortest ratio
   assign dec_len = (ctrl0[4:1] > sdac_pkg::OSR_MAX_CODE) ? 16'd128 :
                    16'(32'd1 << (sdac_pkg::OSR_BASE_LOG - int'(ctrl0[4:1]))); // RULE21

   always_comb begin
      bandgap_en_o = (mode != sdac_pkg::SDAC_PDOWN); // RULE1
      amp_en_o     = bandgap_en_o; // RULE2
      filter_en_o  = bandgap_en_o; // RULE2
      mod_en_o     = (mode == sdac_pkg::SDAC_RUN); // RULE3
      temp_en_o    = mod_en_o && (insel[2:0] == sdac_pkg::SEL_TEMP ||
                     insel[5:3] == sdac_pkg::SEL_TEMP); // RULE16
      nbuf_en_o    = mod_en_o && ctrl1[sdac_pkg::C1_NBUF]; // RULE17
      pbuf_en_o    = mod_en_o && ctrl1[sdac_pkg::C1_PBUF]; // RULE17
      filter_rst_o = mod_en_o && ctrl0[sdac_pkg::C0_FRST]; // RULE4
   end
   assign ref_ext_o  = ctrl0[sdac_pkg::C0_REFS]; // RULE9
   assign osr_code_o = ctrl0[4:1];
   assign rate_div_o = ctrl1[7:5];
   assign clk_div_o  = clksel[4:0];

   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ctrl0  <= sdac_pkg::RST_CTRL0;
         clksel <= sdac_pkg::RST_CLKSEL;
         trim   <= sdac_pkg::RST_TRIM;
         insel  <= sdac_pkg::RST_INSEL;
      end else if (bus.wr) begin
         unique case (bus.addr)
            sdac_pkg::ADDR_CTRL0:  ctrl0  <= bus.wdata;
            sdac_pkg::ADDR_CLKSEL: clksel <= {3'h0, bus.wdata[4:0]};
            sdac_pkg::ADDR_TRIM:   trim   <= bus.wdata;
            sdac_pkg::ADDR_INSEL:  insel  <= {2'h0, bus.wdata[5:0]};
            default: ;
         endcase
      end
   end

   // Done flag: hardware set wins over a software clear in the same cycle
   always_ff @(posedge clk_i) begin
      if (srst_i) begin
         ctrl1 <= sdac_pkg::RST_CTRL1;
      end else begin
         if (bus.wr && bus.addr == sdac_pkg::ADDR_CTRL1)
            ctrl1 <= {bus.wdata[7:2], bus.wdata[1] & ctrl1[1], 1'b0}; // RULE18
         if (done)
            ctrl1[sdac_pkg::C1_DONE] <= 1'b1; // RULE6
      end
   end

   // Decimation: filter runs only in normal mode with reset released
   always_ff @(posedge clk_i) begin
      done <= 1'b0;
      if (srst_i) begin
         dec_cnt <= 16'h0;
         acc     <= '0;
         armed   <= 1'b0;
      end else if (filter_rst_o) begin
         dec_cnt <= 16'h0; // RULE19
         acc     <= '0;
         armed   <= 1'b1; // RULE5
      end else if (mode == sdac_pkg::SDAC_RUN && armed && sample_valid_i) begin
         if (dec_cnt == dec_len - 16'h1) begin
            dec_cnt <= 16'h0;
            // Closing sample kept; the result stage reads it one cycle later
            acc     <= sample_i;
            done    <= 1'b1;
         end else begin
            dec_cnt <= dec_cnt + 16'h1;
            acc     <= sample_i;
         end
      end
   end

   // Whole word captured at once so bytes always match one sample
   always_ff @(posedge clk_i) begin
      if (srst_i) result <= 24'h0;
      else if (done && !ctrl1[sdac_pkg::C1_HOLD]) // RULE7 RULE8 RULE20
         result <= sdac_pkg::sdac_sat(acc); // RULE10 RULE11 RULE22
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) bus.rdata <= 8'h0;
      else if (bus.rd) begin
         unique case (bus.addr)
            sdac_pkg::ADDR_RES_LOW:  bus.rdata <= result[7:0]; // RULE12
            sdac_pkg::ADDR_RES_MID:  bus.rdata <= result[15:8];
            sdac_pkg::ADDR_RES_HIGH: bus.rdata <= result[23:16];
            sdac_pkg::ADDR_CTRL0:    bus.rdata <= ctrl0;
            sdac_pkg::ADDR_CTRL1:    bus.rdata <= ctrl1;
            sdac_pkg::ADDR_CLKSEL:   bus.rdata <= clksel;
            sdac_pkg::ADDR_TRIM:     bus.rdata <= trim;
            sdac_pkg::ADDR_INSEL:    bus.rdata <= insel;
            default:                 bus.rdata <= 8'h0;
         endcase
      end
   end
endmodule

// File: design/sdac_host.sv
`timescale 1ns/1ps
module sdac_host (
   // Clock and reset
   input  wire logic        clk_i,
   input  wire logic        srst_i,
   // Avalon-MM slave
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   // Device port
   sdac_if.host             dev
);
   typedef enum logic [5:0] {
      ST_IDLE = 6'b000001,
      ST_RD   = 6'b000010,
      ST_WAIT = 6'b000100,
      ST_SEQ  = 6'b001000,
      ST_POLL = 6'b010000,
      ST_DONE = 6'b100000
   } sdac_hst_e;
   sdac_hst_e   st;
   logic [3:0]  step;
   logic [7:0]  last;
   logic [23:0] result;
   logic        busy;
   logic        rd_ack;

   // A read waits one cycle so registered data stands when it is accepted
   assign avs_waitrequest = avs_read && !rd_ack;

   always_ff @(posedge clk_i) begin
      if (srst_i) rd_ack <= 1'b0;
      else rd_ack <= avs_read && !rd_ack;
   end

   always_ff @(posedge clk_i) begin
      if (srst_i) avs_readdata <= 32'h0;
      else if (avs_read && !rd_ack) begin
         unique case (avs_address)
            sdac_pkg::HA_STATUS: avs_readdata <= {23'h0, busy, last};
            sdac_pkg::HA_RESULT: avs_readdata <= {8'h0, result};
            default:             avs_readdata <= 32'h0;
         endcase
      end
   end

   // Start sequence: trim, clock, configure, power up, filter pulse, poll, read
   always_ff @(posedge clk_i) begin
      dev.wr <= 1'b0;
      dev.rd <= 1'b0;
      if (srst_i) begin
         st <= ST_IDLE;
         step <= 4'h0;
         busy <= 1'b0;
         last <= 8'h0;
         result <= 24'h0;
         dev.addr <= 8'h0;
         dev.wdata <= 8'h0;
      end else begin
         unique case (st)
            ST_IDLE: if (avs_write && avs_address == sdac_pkg::HA_CMD) begin
               busy <= 1'b1;
               dev.addr <= avs_writedata[15:8];
               dev.wdata <= avs_writedata[7:0];
               unique case (avs_writedata[17:16])
                  sdac_pkg::CMD_WRITE: begin dev.wr <= 1'b1; st <= ST_WAIT; end
                  sdac_pkg::CMD_READ:  begin dev.rd <= 1'b1; st <= ST_RD; end
                  sdac_pkg::CMD_START: begin step <= 4'h0; st <= ST_SEQ; end
                  default: busy <= 1'b0;
               endcase
            end
            ST_RD: st <= ST_WAIT;
            ST_WAIT: begin
               last <= dev.rdata;
               busy <= 1'b0;
               st <= ST_IDLE;
            end
            ST_SEQ: begin
               step <= step + 4'h1;
               // Odd steps leave a gap so every strobe stays a single pulse
               if (!step[0]) begin
                  dev.wr <= 1'b1;
                  unique case (step[3:1])
                     3'h0: begin dev.addr <= sdac_pkg::ADDR_TRIM;
                        dev.wdata <= sdac_pkg::TRIM_REQ; end // RULE13
                     3'h1: begin dev.addr <= sdac_pkg::ADDR_CLKSEL;
                        dev.wdata <= sdac_pkg::CLKSEL_NOM; end // RULE15
                     3'h2: begin dev.addr <= sdac_pkg::ADDR_CTRL0;
                        dev.wdata <= 8'h22; end // RULE14
                     3'h3: begin dev.addr <= sdac_pkg::ADDR_CTRL0;
                        dev.wdata <= 8'h02; end // RULE14
                     3'h4: begin dev.addr <= sdac_pkg::ADDR_CTRL0;
                        dev.wdata <= 8'h82; end // RULE5
                     default: begin dev.addr <= sdac_pkg::ADDR_CTRL0;
                        dev.wdata <= 8'h02; st <= ST_POLL; step <= 4'h0; end // RULE5
                  endcase
               end
            end
            ST_POLL: begin
               step <= step + 4'h1;
               if (step[0] == 1'b0) begin
                  dev.rd <= 1'b1;
                  dev.addr <= sdac_pkg::ADDR_CTRL1;
               end else if (step[1] && dev.rdata[sdac_pkg::C1_DONE]) begin
                  st <= ST_DONE; // RULE14
                  step <= 4'h0;
               end
            end
            ST_DONE: begin
               step <= step + 4'h1;
               unique case (step)
                  4'h0: begin dev.rd <= 1'b1; dev.addr <= sdac_pkg::ADDR_RES_LOW; end
                  4'h1, 4'h3, 4'h5: ;
                  4'h2: begin dev.rd <= 1'b1; dev.addr <= sdac_pkg::ADDR_RES_MID;
                     result[7:0] <= dev.rdata; end
                  4'h4: begin dev.rd <= 1'b1; dev.addr <= sdac_pkg::ADDR_RES_HIGH;
                     result[15:8] <= dev.rdata; end
                  4'h6: result[23:16] <= dev.rdata;
                  default: begin
                     dev.wr <= 1'b1; dev.addr <= sdac_pkg::ADDR_CTRL1;
                     dev.wdata <= 8'h00; // RULE18
                     busy <= 1'b0; st <= ST_IDLE;
                  end
               endcase
            end
            default: st <= ST_IDLE;
         endcase
      end
   end
endmodule

// File: bench/sdac_props.sv
`timescale 1ns/1ps
module sdac_props (
   // Clock and reset
   input wire logic       clk_i,
   input wire logic       srst_i,
   // Device port
   input wire logic       wr,
   input wire logic       rd,
   input wire logic [7:0] addr,
   input wire logic [7:0] wdata,
   input wire logic [7:0] rdata
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (srst_i);
   sequence s_frst_on;
      wr && addr == sdac_pkg::ADDR_CTRL0 && wdata[sdac_pkg::C0_FRST];
   endsequence
   sequence s_frst_off;
      wr && addr == sdac_pkg::ADDR_CTRL0 && !wdata[sdac_pkg::C0_FRST];
   endsequence
   // A filter reset left high stalls conversions forever
   a_frst_pulse: assert property (s_frst_on |-> ##[1:400] s_frst_off)
      else $error("filter reset not released");
   a_trim_fixed: assert property (wr && addr == sdac_pkg::ADDR_TRIM
      |-> wdata == sdac_pkg::TRIM_REQ) else $error("trim written with wrong pattern");
   a_clk_nominal: assert property (wr && addr == sdac_pkg::ADDR_CLKSEL
      |-> wdata[4:0] == sdac_pkg::CLKSEL_NOM[4:0]) else $error("clock divider not nominal");
   a_wr_single: assert property (wr |=> !wr)
      else $error("write strobe longer than one cycle");
   a_rd_single: assert property (rd |=> !rd)
      else $error("read strobe longer than one cycle");
   a_rw_excl: assert property (!(wr && rd))
      else $error("read and write together");
   a_rdata_hold: assert property (!rd |=> $stable(rdata))
      else $error("read data changed without a read");
   a_unmapped_zero: assert property (rd && addr == 8'h00 |=> rdata == 8'h00)
      else $error("unmapped read not zero");
endmodule

// File: bench/testbench.sv
`timescale 1ns/1ps
`define EXPECT(e, a) begin q_exp.push_back(32'(e)); q_act.push_back(32'(a)); end
module testbench;
   logic               clk_i = 1'b0;
   logic               srst_i = 1'b1;
   logic [3:0]         avs_address = 4'h0;
   logic               avs_read = 1'b0;
   logic               avs_write = 1'b0;
   logic [31:0]        avs_writedata = 32'h0;
   logic [31:0]        avs_readdata;
   logic               avs_waitrequest;
   logic signed [25:0] sample_i = 26'sh0;
   logic signed [25:0] smp = 26'sh0;
   logic               sample_valid_i = 1'b0;
   logic               bg, amp, mdl, tmp, nb, pb, fe, fr, rx;
   logic [3:0]         osr;
   logic [4:0]         cdiv;
   logic [2:0]         rdiv;
   logic [31:0]        q_exp[$], q_act[$], rd_v, a_v, e_v;
   int                 n_errors = 0, checks_done = 0, seed = 54835;
   sdac_if i_sdac_if ();
   sdac_dev i_sdac_dev (.clk_i(clk_i), .srst_i(srst_i), .bus(i_sdac_if.dev),
      .sample_i(sample_i), .sample_valid_i(sample_valid_i), .bandgap_en_o(bg), .amp_en_o(amp),
      .mod_en_o(mdl), .temp_en_o(tmp), .nbuf_en_o(nb), .pbuf_en_o(pb), .filter_en_o(fe),
      .filter_rst_o(fr), .ref_ext_o(rx), .osr_code_o(osr), .rate_div_o(rdiv), .clk_div_o(cdiv));
   sdac_host i_sdac_host (.clk_i(clk_i), .srst_i(srst_i), .avs_address(avs_address),
      .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .dev(i_sdac_if.host));
   sdac_props i_sdac_props (.clk_i(clk_i), .srst_i(srst_i), .wr(i_sdac_if.wr),
      .rd(i_sdac_if.rd), .addr(i_sdac_if.addr), .wdata(i_sdac_if.wdata),
      .rdata(i_sdac_if.rdata));
   initial begin
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      sample_i <= smp;
   end
   function automatic logic [23:0] sat(input logic signed [25:0] v);
      if (v > 26'sh07fffff) return 24'h7fffff;
      if (v < -26'sh0800000) return 24'h800000;
      return v[23:0];
   endfunction
   task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= w;
      avs_read <= !w;
      @(posedge clk_i);
      while (avs_waitrequest !== 1'b0) @(posedge clk_i);
      rd_v = avs_readdata;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
      @(posedge clk_i);
   endtask
   task automatic cmd(input logic [1:0] op, input logic [7:0] a, input logic [7:0] d);
      int n = 0;
      av(1'b1, sdac_pkg::HA_CMD, {14'h0, op, a, d});
      rd_v = 32'h100;
      // Busy clears late for a start command, so the bound is generous
      while (rd_v[8] !== 1'b0 && n < 40000) begin
         av(1'b0, sdac_pkg::HA_STATUS, 32'h0);
         n++;
      end
      if (n >= 40000) n_errors++;
   endtask
   task automatic dread(input logic [7:0] a);
      cmd(sdac_pkg::CMD_READ, a, 8'h00);
      // Low status byte holds what the host fetched
      rd_v = {24'h0, rd_v[7:0]};
   endtask
   task automatic poll_done();
      int n = 0;
      do begin
         dread(sdac_pkg::ADDR_CTRL1);
         n++;
      end while (rd_v[1] !== 1'b1 && n < 100);
      `EXPECT(1'b1, rd_v[1])
   endtask
   task automatic check_res(input logic [23:0] x);
      logic [23:0] r;
      dread(sdac_pkg::ADDR_RES_LOW);
      r[7:0] = rd_v[7:0];
      dread(sdac_pkg::ADDR_RES_MID);
      r[15:8] = rd_v[7:0];
      dread(sdac_pkg::ADDR_RES_HIGH);
      r[23:16] = rd_v[7:0];
      `EXPECT(x, r)
   endtask
   task automatic final_report();
      #1;
      $display("errors %0d checks %0d", n_errors, checks_done);
      if (n_errors == 0 && checks_done > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   initial begin
      forever begin
         wait (q_act.size() > 0);
         a_v = q_act.pop_front();
         e_v = q_exp.pop_front();
         checks_done++;
         if (a_v !== e_v) begin
            n_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, a_v, e_v);
         end
      end
   end
   initial begin
      #600000;
      n_errors++;
      final_report();
   end
   initial begin
      logic [7:0]         c0, is, c1;
      logic [6:0]         x7;
      logic signed [25:0] v[5];
      repeat (16) @(posedge clk_i);
      srst_i <= 1'b0;
      sample_valid_i <= 1'b1;
      @(posedge clk_i);
      `EXPECT(7'h00, {bg, amp, mdl, tmp, nb, pb, fe})
      dread(sdac_pkg::ADDR_TRIM);
      `EXPECT(sdac_pkg::RST_TRIM, rd_v)
      dread(8'h00);
      `EXPECT(8'h00, rd_v)
      smp = 26'($signed(24'($random(seed))));
      cmd(sdac_pkg::CMD_START, 8'h00, 8'h00);
      av(1'b0, sdac_pkg::HA_RESULT, 32'h0);
      `EXPECT(sat(smp), rd_v[23:0])
      `EXPECT(5'h1f, cdiv)
      dread(sdac_pkg::ADDR_TRIM);
      `EXPECT(sdac_pkg::TRIM_REQ, rd_v)
      for (int k = 0; k < 16; k++) begin
         is = 8'($random(seed)) & 8'h3f;
         if (k[3]) is[2:0] = sdac_pkg::SEL_TEMP;
         c1 = 8'($random(seed)) & 8'hf8;
         c0 = {k[0], k[2], k[1], 4'(k % 9), 1'($random(seed))};
         cmd(sdac_pkg::CMD_WRITE, sdac_pkg::ADDR_INSEL, is);
         cmd(sdac_pkg::CMD_WRITE, sdac_pkg::ADDR_CTRL1, c1);
         cmd(sdac_pkg::CMD_WRITE, sdac_pkg::ADDR_CTRL0, c0);
         x7 = {3'h7, is[2:0] == 3'h7 || is[5:3] == 3'h7, c1[4], c1[3], k[0]};
         if (k[1]) x7 = 7'h00;
         else if (k[2]) x7 = 7'h61;
         `EXPECT(x7, {bg, amp, mdl, tmp, nb, pb, (k[1] | k[2]) ? fe : fr})
         `EXPECT({c1[7:5], c0[4:0]}, {rdiv, osr, rx})
      end
      v = '{26'sh0800000, -26'sh0800001, 26'sh07fffff, -26'sh0800000, 26'sh0a5c3e1};
      foreach (v[i]) begin
         smp = v[i];
         cmd(sdac_pkg::CMD_WRITE, sdac_pkg::ADDR_CTRL0, 8'h90);
         cmd(sdac_pkg::CMD_WRITE, sdac_pkg::ADDR_CTRL1, 8'h00);
         repeat (200) @(posedge clk_i);
         dread(sdac_pkg::ADDR_CTRL1);
         `EXPECT(1'b0, rd_v[1])
         cmd(sdac_pkg::CMD_WRITE, sdac_pkg::ADDR_CTRL0, 8'h10);
         poll_done();
         check_res(sat(v[i]));
      end
      cmd(sdac_pkg::CMD_WRITE, sdac_pkg::ADDR_CTRL1, 8'h04);
      smp = 26'sh0000123;
      repeat (300) @(posedge clk_i);
      dread(sdac_pkg::ADDR_CTRL1);
      `EXPECT(1'b1, rd_v[1])
      check_res(sat(v[4]));
      cmd(sdac_pkg::CMD_WRITE, sdac_pkg::ADDR_CTRL1, 8'h00);
      poll_done();
      check_res(24'h000123);
      cmd(sdac_pkg::CMD_WRITE, sdac_pkg::ADDR_RES_LOW, 8'h5a);
      check_res(24'h000123);
      final_report();
   end
endmodule
